// ===== verilog/yps_pkg.sv
// Package for the Y-protection status reporter
`default_nettype none
package yps_pkg;
    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] YPS_CTRL_OFF    = 12'h000;
    localparam logic [11:0] YPS_CMD_OFF     = 12'h004;
    localparam logic [11:0] YPS_WCFG_OFF    = 12'h008;
    localparam logic [11:0] YPS_PORT_OFF    = 12'h00c;
    localparam logic [11:0] YPS_STAT_OFF    = 12'h010;
    localparam logic [11:0] YPS_COND_OFF    = 12'h014;
    localparam logic [11:0] YPS_PCFG_OFF    = 12'h018;
    localparam logic [11:0] YPS_WTR_OFF     = 12'h01c;
    // CTRL fields
    localparam int CTRL_GROUP_BIT  = 0;
    localparam int CTRL_REVERT_BIT = 1;
    localparam int CTRL_MULTI_BIT  = 2;
    localparam int CTRL_FARK_BIT   = 3;
    localparam int CTRL_FARA_BIT   = 4;
    localparam int CTRL_SPLIT_BIT  = 5;
    localparam int CTRL_TPULSE_BIT = 6;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    // ------------------------------------------------------------------
    // Switch command codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_CLEAR   = 3'h0,
        CMD_MAN_WP  = 3'h1,
        CMD_MAN_PW  = 3'h2,
        CMD_FRC_WP  = 3'h3,
        CMD_FRC_PW  = 3'h4,
        CMD_LOCKOUT = 3'h5
    } yps_cmd_t;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_GAP   = 4'b0010,
        ST_DONE  = 4'b0100,
        ST_HOLD  = 4'b1000
    } yps_state_t;
    // ------------------------------------------------------------------
    // Per-facility line defects
    // ------------------------------------------------------------------
    typedef struct packed {
        logic frame_loss;
        logic signal_loss;
        logic eth_oos;
        logic optic_missing;
        logic optic_mismatch;
        logic optic_fail;
        logic admin_disabled;
        logic overhead_traffic;
        logic in_service;
        logic light_loss;
        logic degrade;
    } yps_fac_t;
    // Timing
    localparam int  CLK_MHZ        = 200;
    localparam int  GAP_MS         = 20;
    localparam int  GAP_BUDGET_US  = 100;
    localparam int  GAP_CYC        = GAP_BUDGET_US * CLK_MHZ;
    localparam int  GAP_LIMIT_CYC  = GAP_MS * 1000 * CLK_MHZ;
    localparam int  PULSE_CYC      = 1000 * CLK_MHZ;
    localparam int  PULSE_PERIOD   = 100000 * CLK_MHZ;
    localparam logic [31:0] WTR_RST = 32'h0000_1000;
endpackage
`default_nettype wire

// ===== verilog/yps_status_reporter.sv
// Y-protection status, condition and switch control with APB registers
// Function
// RULE1 - Protect port settings are copied from working port settings
// RULE2 - Exactly one facility is internally active, the other standby
// RULE3 - Admin-disabled member port reports standby
// RULE4 - Enabled port carrying overhead traffic reports active
// RULE5 - Client reports active when enabled and internally active
// RULE6 - Trunk active if enabled and a client active; multi needs service
// RULE7 - Ungrouped ports report active when not admin disabled
// RULE8 - Receive status is own; transmit is far-end if known else own
// RULE9 - At most one client port is active at a time
// RULE10 - Manual command holds manual-request on the facility left
// RULE11 - Forced command holds forced-request on the facility left
// RULE12 - Lockout holds lockout-request on protection facility
// RULE13 - Pulse command-cleared when a command is preempted
// RULE14 - Failed-to-switch while a command blocks a line switch
// RULE15 - Restore-wait on working while restore timer runs
// RULE16 - Revertive: switched-to-protect held while protection active
// RULE17 - Nonrevertive: pulse switched-to-protect and switched-back
// RULE18 - Switch completes within 50 ms of a near-end defect
// RULE19 - Standby transmitter off, active on, light gap under 20 ms
// RULE20 - Loss of light shuts transmitter; optional test pulses
// RULE21 - Laser shutdown only on splitter ports, never Y-cable clients
// RULE22 - Client signal fail on frame, signal, sync, optics or disable
`timescale 1ns/100ps
`default_nettype none
module yps_status_reporter
    import yps_pkg::*;
#(
    parameter int GAP_CYCLES  = GAP_CYC,
    parameter int WTR_UNIT    = 1000,
    parameter int PULSE_ON    = PULSE_CYC,
    parameter int PULSE_EVERY = PULSE_PERIOD
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    input  wire yps_fac_t    WORK_FAC,
    input  wire yps_fac_t    PROT_FAC,
    output var  logic [1:0]  RX_ACTIVE,
    output var  logic [1:0]  TX_ACTIVE,
    output var  logic [1:0]  TRUNK_ACTIVE,
    output var  logic [1:0]  LASER_ON,
    output var  logic [1:0]  CLIENT_SIGNAL_FAIL,
    output var  logic [31:0] PROT_SETTINGS,
    output var  logic        COMMAND_CLEARED_EVENT,
    output var  logic        WORKING_SWITCHED_TO_PROTECT,
    output var  logic        WORKING_SWITCHED_BACK
);
    if (GAP_CYCLES < 1 || GAP_CYCLES >= GAP_LIMIT_CYC || WTR_UNIT < 1
        || PULSE_ON < 1 || PULSE_EVERY <= PULSE_ON) begin : g_bad_param
        $error("timer parameters out of range");
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [2:0]  cmd_reg;
    logic [31:0] wcfg_reg;
    logic [31:0] wtr_reg;
    logic [31:0] wtr_cnt_reg;
    logic        prot_act_reg;
    logic        prot_act_next;
    yps_state_t  state_reg;
    logic [31:0] gap_cnt_reg;
    logic [31:0] pulse_cnt_reg;

    wire apb_wr = PSEL && PENABLE && PWRITE && PREADY;
    wire apb_rd = PSEL && !PENABLE && !PWRITE;
    wire sel_ctrl = (PADDR == YPS_CTRL_OFF);
    wire sel_cmd  = (PADDR == YPS_CMD_OFF);
    wire sel_wcfg = (PADDR == YPS_WCFG_OFF);
    wire sel_port = (PADDR == YPS_PORT_OFF);
    wire sel_stat = (PADDR == YPS_STAT_OFF);
    wire sel_cond = (PADDR == YPS_COND_OFF);
    wire sel_pcfg = (PADDR == YPS_PCFG_OFF);
    wire sel_wtr  = (PADDR == YPS_WTR_OFF);
    wire sel_any  = (PADDR <= YPS_WTR_OFF) && (PADDR[1:0] == 2'h0);

    wire grouped  = ctrl_reg[CTRL_GROUP_BIT];
    wire revert   = ctrl_reg[CTRL_REVERT_BIT];
    wire multi    = ctrl_reg[CTRL_MULTI_BIT];
    wire far_kn   = ctrl_reg[CTRL_FARK_BIT];
    wire far_act  = ctrl_reg[CTRL_FARA_BIT];
    wire splitter = ctrl_reg[CTRL_SPLIT_BIT];
    wire tpulse   = ctrl_reg[CTRL_TPULSE_BIT];

    // ------------------------------------------------------------------
    // Switch decision
    // ------------------------------------------------------------------
    wire w_csf = WORK_FAC.frame_loss || WORK_FAC.signal_loss
              || WORK_FAC.eth_oos || WORK_FAC.optic_missing
              || WORK_FAC.optic_mismatch || WORK_FAC.optic_fail
              || WORK_FAC.admin_disabled; // RULE22
    wire p_csf = PROT_FAC.frame_loss || PROT_FAC.signal_loss
              || PROT_FAC.eth_oos || PROT_FAC.optic_missing
              || PROT_FAC.optic_mismatch || PROT_FAC.optic_fail
              || PROT_FAC.admin_disabled; // RULE22
    wire w_sf  = w_csf || WORK_FAC.degrade;
    wire p_sf  = p_csf || PROT_FAC.degrade;
    wire lockout = (cmd_reg == CMD_LOCKOUT);
    wire frc_wp  = (cmd_reg == CMD_FRC_WP);
    wire frc_pw  = (cmd_reg == CMD_FRC_PW);
    wire man_wp  = (cmd_reg == CMD_MAN_WP);
    wire man_pw  = (cmd_reg == CMD_MAN_PW);
    // Line wish: where traffic should go from defects alone
    wire line_to_p = w_sf && !p_sf;
    wire line_to_w = p_sf && !w_sf;
    wire wtr_run   = (wtr_cnt_reg != 32'h0);
    // Manual loses to a line failure; forced and lockout hold
    wire man_preempt = (man_wp && p_sf) || (man_pw && w_sf);
    wire blocked = (lockout && line_to_p) || (frc_pw && line_to_p)
                || (frc_wp && line_to_w);
    always_comb begin
        prot_act_next = prot_act_reg;
        if (lockout || frc_pw) begin
            prot_act_next = 1'b0;
        end else if (frc_wp) begin
            prot_act_next = 1'b1;
        end else if (line_to_p) begin
            prot_act_next = 1'b1;
        end else if (line_to_w) begin
            prot_act_next = 1'b0;
        end else if (man_wp && !man_preempt) begin
            prot_act_next = 1'b1;
        end else if (man_pw && !man_preempt) begin
            prot_act_next = 1'b0;
        end else if (revert && prot_act_reg && !w_sf && !wtr_run
                     && wtr_reg != 32'h0) begin
            prot_act_next = 1'b0;
        end
    end
    wire want_switch = (prot_act_next != prot_act_reg);

    // ------------------------------------------------------------------
    // Switch sequencer: one internal active always, bounded light gap
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_reg    <= ST_IDLE;
            prot_act_reg <= 1'b0;
            gap_cnt_reg  <= 32'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (want_switch) begin
                        state_reg    <= ST_GAP; // RULE18
                        prot_act_reg <= prot_act_next; // RULE2
                        gap_cnt_reg  <= 32'h0;
                    end
                end
                ST_GAP: begin
                    gap_cnt_reg <= gap_cnt_reg + 32'h1;
                    if (gap_cnt_reg >= 32'(GAP_CYCLES - 1)) begin
                        state_reg <= ST_DONE; // RULE19
                    end
                end
                ST_DONE: state_reg <= ST_HOLD;
                ST_HOLD: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
    wire in_gap = (state_reg == ST_GAP);

    // ------------------------------------------------------------------
    // Restore-wait timer (revertive only)
    // ------------------------------------------------------------------
    logic [31:0] wtr_unit_cnt_reg;
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            wtr_cnt_reg      <= 32'h0;
            wtr_unit_cnt_reg <= 32'h0;
        end else if (!revert || !prot_act_reg || w_sf) begin
            wtr_cnt_reg      <= revert && prot_act_reg ? wtr_reg : 32'h0;
            wtr_unit_cnt_reg <= 32'h0;
        end else if (wtr_run) begin
            if (wtr_unit_cnt_reg >= 32'(WTR_UNIT - 1)) begin
                wtr_unit_cnt_reg <= 32'h0;
                wtr_cnt_reg      <= wtr_cnt_reg - 32'h1; // RULE15
            end else begin
                wtr_unit_cnt_reg <= wtr_unit_cnt_reg + 32'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Reported status
    // ------------------------------------------------------------------
    wire w_int = !prot_act_reg;
    wire p_int = prot_act_reg;
    wire w_on  = !WORK_FAC.admin_disabled;
    wire p_on  = !PROT_FAC.admin_disabled;
    // In a group only one client may be lit; the other forced off
    wire w_cli = w_on && (!grouped || w_int); // RULE5 RULE7 RULE9
    wire p_cli = p_on && (!grouped || p_int); // RULE5 RULE7 RULE9
    wire w_rep = w_on && (w_cli || WORK_FAC.overhead_traffic); // RULE3 RULE4
    wire p_rep = p_on && (p_cli || PROT_FAC.overhead_traffic); // RULE3 RULE4
    wire w_trk = w_on && (!grouped
              || (w_cli && (!multi || WORK_FAC.in_service))); // RULE6 RULE7
    wire p_trk = p_on && (!grouped
              || (p_cli && (!multi || PROT_FAC.in_service))); // RULE6 RULE7
    // Far-end control bit set means the far-end protect side carries
    wire w_tx  = far_kn ? (w_on && !far_act) : w_rep; // RULE8
    wire p_tx  = far_kn ? (p_on && far_act) : p_rep; // RULE8

    // Laser shutdown only where allowed
    wire als_ok  = wcfg_reg[0] && splitter; // RULE21
    wire w_shut  = als_ok && WORK_FAC.light_loss; // RULE20
    wire p_shut  = als_ok && PROT_FAC.light_loss; // RULE20
    wire pulse_on = tpulse && (pulse_cnt_reg < 32'(PULSE_ON));
    wire w_laser = (!grouped || w_int) && !in_gap
                && (!w_shut || pulse_on); // RULE19 RULE20
    wire p_laser = (!grouped || p_int) && !in_gap
                && (!p_shut || pulse_on); // RULE19 RULE20

    // ------------------------------------------------------------------
    // Conditions, bit 0 first here, last in cond_bits
    // ------------------------------------------------------------------
    wire manual_request_cond_w = man_wp; // RULE10
    wire manual_request_cond_p = man_pw; // RULE10
    wire forced_request_cond_w = frc_wp; // RULE11
    wire forced_request_cond_p = frc_pw; // RULE11
    wire lockout_request_cond  = lockout; // RULE12
    wire failed_to_switch_cond = blocked; // RULE14
    wire restore_wait_cond     = wtr_run; // RULE15
    wire wk_sw_level           = revert && prot_act_reg; // RULE16
    wire [7:0] cond_bits = {wk_sw_level, restore_wait_cond,
                            failed_to_switch_cond, lockout_request_cond,
                            forced_request_cond_p, forced_request_cond_w,
                            manual_request_cond_p, manual_request_cond_w};

    // ------------------------------------------------------------------
    // Bus slave and outputs
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        if (sel_ctrl) rd_mux = ctrl_reg;
        else if (sel_cmd) rd_mux = {29'h0, cmd_reg};
        else if (sel_wcfg) rd_mux = wcfg_reg;
        else if (sel_port) rd_mux = {24'h0, RX_ACTIVE, TX_ACTIVE,
                                     TRUNK_ACTIVE, LASER_ON};
        else if (sel_stat) rd_mux = {27'h0, in_gap, CLIENT_SIGNAL_FAIL,
                                     prot_act_reg, w_int};
        else if (sel_cond) rd_mux = {24'h0, cond_bits};
        else if (sel_pcfg) rd_mux = PROT_SETTINGS;
        else if (sel_wtr) rd_mux = wtr_reg;
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ctrl_reg        <= CTRL_RST;
            cmd_reg         <= CMD_CLEAR;
            wcfg_reg        <= 32'h0;
            wtr_reg         <= WTR_RST;
            pulse_cnt_reg   <= 32'h0;
            PRDATA          <= 32'h0;
            PREADY          <= 1'b0;
            PSLVERR         <= 1'b0;
            RX_ACTIVE       <= 2'h0;
            TX_ACTIVE       <= 2'h0;
            TRUNK_ACTIVE    <= 2'h0;
            LASER_ON        <= 2'h0;
            CLIENT_SIGNAL_FAIL <= 2'h0;
            PROT_SETTINGS   <= 32'h0;
            COMMAND_CLEARED_EVENT       <= 1'b0;
            WORKING_SWITCHED_TO_PROTECT <= 1'b0;
            WORKING_SWITCHED_BACK       <= 1'b0;
        end else begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !sel_any;
            if (apb_rd) PRDATA <= rd_mux;
            if (apb_wr && sel_ctrl) ctrl_reg <= PWDATA;
            if (apb_wr && sel_wcfg) wcfg_reg <= PWDATA;
            if (apb_wr && sel_wtr) wtr_reg <= PWDATA;
            if (apb_wr && sel_cmd) begin
                cmd_reg <= PWDATA[2:0];
            end else if (man_preempt) begin
                cmd_reg <= CMD_CLEAR; // RULE13
            end
            COMMAND_CLEARED_EVENT <= man_preempt
                && !(apb_wr && sel_cmd); // RULE13
            pulse_cnt_reg <= (pulse_cnt_reg >= 32'(PULSE_EVERY - 1))
                           ? 32'h0 : pulse_cnt_reg + 32'h1;
            RX_ACTIVE    <= {p_rep, w_rep}; // RULE8
            TX_ACTIVE    <= {p_tx, w_tx}; // RULE8
            TRUNK_ACTIVE <= {p_trk, w_trk};
            LASER_ON     <= {p_laser, w_laser};
            CLIENT_SIGNAL_FAIL <= {p_csf, w_csf};
            PROT_SETTINGS <= {wcfg_reg[31:1], als_ok}; // RULE1 RULE21
            WORKING_SWITCHED_TO_PROTECT <= !revert && state_reg == ST_IDLE
                && want_switch && prot_act_next; // RULE17
            WORKING_SWITCHED_BACK <= !revert && state_reg == ST_IDLE
                && want_switch && !prot_act_next; // RULE17
        end
    end
endmodule
`default_nettype wire

// ===== dv/yps_far_end.sv
// Far-end and line model that drives the facility defect vectors
`timescale 1ns/100ps
`default_nettype none
module yps_far_end
    import yps_pkg::*;
(
    input  wire logic     SYS_CLK,
    input  wire yps_fac_t WORK_SET,
    input  wire yps_fac_t PROT_SET,
    output var  yps_fac_t WORK_FAC,
    output var  yps_fac_t PROT_FAC
);
    // Line state lands one clock after the request, as from a real port
    always_ff @(posedge SYS_CLK) begin
        WORK_FAC <= WORK_SET;
        PROT_FAC <= PROT_SET;
    end
endmodule
`default_nettype wire

// ===== dv/yps_status_reporter_chk.sv
// Port checker for the Y-protection status reporter
`timescale 1ns/100ps
`default_nettype none
module yps_status_reporter_chk
    import yps_pkg::*;
(
    input wire logic        SYS_CLK,
    input wire logic        RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire yps_fac_t    WORK_FAC,
    input wire yps_fac_t    PROT_FAC,
    input wire logic [1:0]  RX_ACTIVE,
    input wire logic [1:0]  TX_ACTIVE,
    input wire logic [1:0]  CLIENT_SIGNAL_FAIL,
    input wire logic [31:0] PROT_SETTINGS,
    input wire logic        COMMAND_CLEARED_EVENT,
    input wire logic        WORKING_SWITCHED_TO_PROTECT,
    input wire logic        WORKING_SWITCHED_BACK
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    logic [31:0] ctrl_q;
    logic [31:0] wcfg_q;
    logic        wcfg_ok;
    wire  apb_wr = PSEL && PENABLE && PREADY && PWRITE;
    wire  w_csf  = |WORK_FAC[10:4];
    wire  p_csf  = |PROT_FAC[10:4];
    wire  [31:0] cfg_exp = wcfg_q & ~(ctrl_q[5] ? 32'h0 : 32'h1);
    // Shadow of the CTRL and WCFG writes that steer the status logic
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ctrl_q  <= CTRL_RST;
            wcfg_q  <= 32'h0;
            wcfg_ok <= 1'b0;
        end else if (apb_wr && PADDR == YPS_CTRL_OFF) begin
            ctrl_q <= PWDATA;
        end else if (apb_wr && PADDR == YPS_WCFG_OFF) begin
            wcfg_q  <= PWDATA;
            wcfg_ok <= 1'b1;
        end
    end
    property p_ready; PSEL && !PENABLE |=> PREADY; endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_unmapped;
        PSEL && !PENABLE && !PWRITE && PADDR > YPS_WTR_OFF
            |=> PSLVERR && PRDATA == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("no slave error");
    property p_work_off; WORK_FAC.admin_disabled [*4] |-> !RX_ACTIVE[0];
    endproperty
    a_work_off: assert property (p_work_off) else $error("work shown");
    property p_prot_off; PROT_FAC.admin_disabled [*4] |-> !RX_ACTIVE[1];
    endproperty
    a_prot_off: assert property (p_prot_off) else $error("prot shown");
    property p_ohd;
        (!PROT_FAC.admin_disabled && PROT_FAC.overhead_traffic) [*4]
            |-> RX_ACTIVE[1];
    endproperty
    a_ohd: assert property (p_ohd) else $error("overhead not active");
    property p_csf_w; w_csf [*4] |-> CLIENT_SIGNAL_FAIL[0]; endproperty
    a_csf_w: assert property (p_csf_w) else $error("no work fail");
    property p_csf_p; p_csf [*4] |-> CLIENT_SIGNAL_FAIL[1]; endproperty
    a_csf_p: assert property (p_csf_p) else $error("no prot fail");
    property p_clr; COMMAND_CLEARED_EVENT |=> !COMMAND_CLEARED_EVENT;
    endproperty
    a_clr: assert property (p_clr) else $error("cleared too long");
    property p_excl;
        !(WORKING_SWITCHED_TO_PROTECT && WORKING_SWITCHED_BACK);
    endproperty
    a_excl: assert property (p_excl) else $error("both events");
    property p_ungrp;
        (!ctrl_q[0] && !WORK_FAC.admin_disabled) [*4] |-> RX_ACTIVE[0];
    endproperty
    a_ungrp: assert property (p_ungrp) else $error("ungrouped idle");
    property p_far;
        (ctrl_q[4:3] == 2'b11 && ctrl_q[0] && WORK_FAC == '0
            && PROT_FAC == '0) [*4] |-> TX_ACTIVE == 2'b10;
    endproperty
    a_far: assert property (p_far) else $error("tx not far end");
    property p_cfg;
        (wcfg_ok && $stable(wcfg_q) && $stable(ctrl_q)) [*3]
            |-> PROT_SETTINGS == cfg_exp;
    endproperty
    a_cfg: assert property (p_cfg) else $error("bad copy");
    c_clr: cover property (COMMAND_CLEARED_EVENT);
    c_wsp: cover property (WORKING_SWITCHED_TO_PROTECT);
    c_err: cover property (PSLVERR && PREADY);
endmodule
bind yps_status_reporter yps_status_reporter_chk u_yps_status_reporter_chk (
    .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .WORK_FAC(WORK_FAC),
    .PROT_FAC(PROT_FAC), .RX_ACTIVE(RX_ACTIVE), .TX_ACTIVE(TX_ACTIVE),
    .CLIENT_SIGNAL_FAIL(CLIENT_SIGNAL_FAIL), .PROT_SETTINGS(PROT_SETTINGS),
    .COMMAND_CLEARED_EVENT(COMMAND_CLEARED_EVENT),
    .WORKING_SWITCHED_TO_PROTECT(WORKING_SWITCHED_TO_PROTECT),
    .WORKING_SWITCHED_BACK(WORKING_SWITCHED_BACK));
`default_nettype wire

// ===== dv/yps_status_reporter_bench.sv
// Self-checking bench for the Y-protection status reporter
`timescale 1ns/100ps
`default_nettype none
module yps_status_reporter_bench;
    import yps_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] padr = 12'h000;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd, pcfg, rd;
    logic        prdy, perr, clr, wsp, wsb, err;
    yps_fac_t    wset = '0;
    yps_fac_t    pset = '0;
    yps_fac_t    wfac, pfac;
    logic [1:0]  rx, tx, trk, lsr, client_signal_fail;
    int          fail_count = 0;
    int          n_compared = 0;
    int          n_clr = 0, n_wsp = 0, n_wsb = 0, cyc = 0;
    always #2.5 clk = ~clk;
    yps_far_end u_yps_far_end (.SYS_CLK(clk), .WORK_SET(wset),
        .PROT_SET(pset), .WORK_FAC(wfac), .PROT_FAC(pfac));
    yps_status_reporter #(.GAP_CYCLES(4), .WTR_UNIT(2), .PULSE_ON(2),
        .PULSE_EVERY(8)) u_yps_status_reporter (.SYS_CLK(clk), .RST(rst),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr),
        .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
        .WORK_FAC(wfac), .PROT_FAC(pfac), .RX_ACTIVE(rx), .TX_ACTIVE(tx),
        .TRUNK_ACTIVE(trk), .LASER_ON(lsr), .CLIENT_SIGNAL_FAIL(client_signal_fail),
        .PROT_SETTINGS(pcfg), .COMMAND_CLEARED_EVENT(clr),
        .WORKING_SWITCHED_TO_PROTECT(wsp), .WORKING_SWITCHED_BACK(wsb));
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Event pulses are counted here and hangs are cut short
    always @(posedge clk) begin
        cyc++;
        n_clr += int'(clr === 1'b1);
        n_wsp += int'(wsp === 1'b1);
        n_wsb += int'(wsb === 1'b1);
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, x, g);
        end
    endtask
    // ------------------------------------------------------------------
    // APB master
    // ------------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1);
        rd = prd;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        chk("pready_wait", 32'h1, 32'(n));
    endtask
    task automatic rd_chk(input string nm, input logic [11:0] a,
                          input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, x, rd);
    endtask
    function automatic logic [1:0] pick(input int s);
        case (s)
            0: return rx;
            1: return tx;
            2: return trk;
            3: return lsr;
            default: return client_signal_fail;
        endcase
    endfunction
    task automatic wait_for(input string nm, input int s,
                            input logic [1:0] x);
        int n;
        n = 0;
        while (pick(s) !== x && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk(nm, {30'h0, x}, {30'h0, pick(s)});
    endtask
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd_chk("ctrl", YPS_CTRL_OFF, CTRL_RST);
        rd_chk("wtr", YPS_WTR_OFF, WTR_RST);
        rd_chk("unmapped", 12'h020, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        wait_for("rx", 0, 2'b01);
        wait_for("tx", 1, 2'b01);
        wait_for("laser", 3, 2'b01);
        wait_for("csf", 4, 2'b00);
        $display("test reset done");
        pset.overhead_traffic <= 1'b1;
        wait_for("rx", 0, 2'b11);
        pset.admin_disabled <= 1'b1;
        wait_for("rx", 0, 2'b01);
        pset <= '0;
        for (int i = 10; i >= 4; i--) begin
            @(posedge clk);
            pset <= yps_fac_t'(11'h001 << i);
            wait_for("csf", 4, 2'b10);
            pset <= '0;
            wait_for("csf", 4, 2'b00);
        end
        $display("test reporting done");
        apb(1'b1, YPS_CTRL_OFF, 32'h0);
        wait_for("rx", 0, 2'b11);
        wait_for("trunk", 2, 2'b11);
        apb(1'b1, YPS_CTRL_OFF, 32'h19);
        wait_for("tx", 1, 2'b10);
        apb(1'b1, YPS_CTRL_OFF, 32'h09);
        wait_for("tx", 1, 2'b01);
        apb(1'b1, YPS_CTRL_OFF, CTRL_RST);
        $display("test grouping done");
        apb(1'b1, YPS_CMD_OFF, {29'h0, CMD_FRC_WP});
        wait_for("rx", 0, 2'b10);
        wait_for("laser", 3, 2'b10);
        wait_for("trunk", 2, 2'b10);
        apb(1'b1, YPS_CMD_OFF, {29'h0, CMD_FRC_PW});
        wait_for("rx", 0, 2'b01);
        repeat (8) @(posedge clk);
        chk("wsp_count", 32'h1, 32'(n_wsp));
        chk("wsb_count", 32'h1, 32'(n_wsb));
        apb(1'b1, YPS_CMD_OFF, {29'h0, CMD_MAN_WP});
        wait_for("rx", 0, 2'b10);
        pset.signal_loss <= 1'b1;
        wait_for("rx", 0, 2'b01);
        repeat (8) @(posedge clk);
        chk("clr_count", 32'h1, 32'(n_clr));
        pset <= '0;
        wset.signal_loss <= 1'b1;
        wait_for("rx", 0, 2'b10);
        wset <= '0;
        repeat (8) @(posedge clk);
        wait_for("rx", 0, 2'b10);
        chk("wsp_count", 32'h3, 32'(n_wsp));
        apb(1'b1, YPS_CMD_OFF, {29'h0, CMD_FRC_PW});
        wait_for("rx", 0, 2'b01);
        apb(1'b1, YPS_CMD_OFF, {29'h0, CMD_LOCKOUT});
        wset.signal_loss <= 1'b1;
        rd_chk("cond", YPS_COND_OFF, 32'h30);
        apb(1'b1, YPS_WTR_OFF, 32'h4);
        apb(1'b1, YPS_CTRL_OFF, 32'h3);
        apb(1'b1, YPS_CMD_OFF, {29'h0, CMD_CLEAR});
        wait_for("rx", 0, 2'b10);
        rd_chk("cond", YPS_COND_OFF, 32'hc0);
        wset <= '0;
        wait_for("rx", 0, 2'b01);
        $display("test switching done");
        apb(1'b1, YPS_WCFG_OFF, 32'h0000_00a5);
        rd_chk("pcfg", YPS_PCFG_OFF, 32'h0000_00a4);
        chk("prot_settings", 32'h0000_00a4, pcfg);
        apb(1'b1, YPS_CTRL_OFF, 32'h21);
        rd_chk("pcfg", YPS_PCFG_OFF, 32'h0000_00a5);
        wset.light_loss <= 1'b1;
        wait_for("laser", 3, 2'b00);
        $display("test laser done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
